// file: tec_pkg.sv
package tec_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_PRESCALE = 4'h2;
    localparam logic [3:0] ADDR_PERIOD = 4'h3;
    localparam logic [3:0] ADDR_DUTY = 4'h4;
    localparam logic [3:0] ADDR_COUNT = 4'h5;
    localparam logic [3:0] ADDR_CAP_A = 4'h6;
    localparam logic [3:0] ADDR_CAP_B = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_TRIG = 4'h9;
    // mode register fields
    localparam int unsigned MODE_OP_LO = 0;
    localparam int unsigned MODE_FN_LO = 2;
    // control register fields
    localparam int unsigned CTRL_PAD_IS_CAPTURE = 0;
    localparam int unsigned CTRL_EDGE_RISE = 1;
    localparam int unsigned CTRL_EDGE_FALL = 2;
    localparam int unsigned CTRL_OUT_INIT = 3;
    localparam logic [15:0] RESET_PERIOD = 16'hffff;
    localparam logic [15:0] RESET_DUTY = 16'h0000;
    localparam logic [2:0] RESET_PRESCALE = 3'h0;
    localparam logic [3:0] RESET_CTRL = 4'h2;
    localparam int unsigned FILTER_SAMPLES = 2;
    localparam int unsigned EVENT_START_EDGES = 2;
    typedef enum logic [1:0] {
        TEC_OP_STOP, TEC_OP_FREE, TEC_OP_CLEAR_EDGE, TEC_OP_CLEAR_MATCH
    } tec_op_type;
    typedef enum logic [2:0] {
        TEC_FN_INTERVAL, TEC_FN_EVENT, TEC_FN_PULSE_WIDTH, TEC_FN_SQUARE,
        TEC_FN_PPG, TEC_FN_ONESHOT
    } tec_fn_type;
endpackage : tec_pkg

// file: tec_timer.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module tec_timer
    import tec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic primary_edge_input,
    input wire logic shared_pad_in,
    output logic shared_pad_out,
    output logic shared_pad_oe
);
    logic [15:0] up_counter16_reg, up_counter16_next;
    logic [15:0] period_compare_reg, period_compare_next;
    logic [15:0] duty_compare_reg, duty_compare_next;
    logic [15:0] cap_a_reg, cap_a_next, cap_b_reg, cap_b_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [4:0] mode_reg, mode_next;
    logic [3:0] capture_compare_ctrl_reg, capture_compare_ctrl_next;
    logic [2:0] prescaler_select_reg, prescaler_select_next;
    logic [7:0] pre_cnt_reg, pre_cnt_next;
    logic [1:0] pe_sync_reg, sc_sync_reg;
    logic pe_last_reg, pe_last_next;
    logic [1:0] pf_hist_reg, pf_hist_next, sf_hist_reg, sf_hist_next;
    logic pf_arm_reg, pf_arm_next, sf_arm_reg, sf_arm_next;
    logic [1:0] ev_edges_reg, ev_edges_next;
    logic out_reg, out_next;
    logic oneshot_run_reg, oneshot_run_next;
    logic ovf_reg, ovf_next;
    tec_op_type op;
    tec_fn_type fn;
    logic pre_tick, pe_fast_edge, pf_capture, sf_capture, oneshot_trigger_bit;
    logic running, cnt_step, match_period, match_duty, pad_capture, sc_level;

    assign op = tec_op_type'(mode_reg[MODE_OP_LO +: 2]);
    assign fn = tec_fn_type'(mode_reg[MODE_FN_LO +: 3]);
    assign running = (op != TEC_OP_STOP);
    assign pad_capture = capture_compare_ctrl_reg[CTRL_PAD_IS_CAPTURE];
    // gated after the synchroniser so no logic sits ahead of the first flop
    assign sc_level = sc_sync_reg[1] && pad_capture;
    assign oneshot_trigger_bit = reg_wr && (reg_addr == ADDR_TRIG) && reg_wdata[0];
    assign pre_tick = (pre_cnt_next == 8'h00);
    assign match_period = (up_counter16_reg == period_compare_reg);
    assign match_duty = (up_counter16_reg == duty_compare_reg);

    // pad direction chosen by one bit so both functions can never be live together
    assign shared_pad_oe = !pad_capture;
    assign shared_pad_out = pad_capture ? 1'b0 : out_reg;
    assign reg_rdata = rdata_reg;

    // pins cross into the clock domain through two flops before any logic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pe_sync_reg <= 2'h0;
            sc_sync_reg <= 2'h0;
        end else begin
            pe_sync_reg <= {pe_sync_reg[0], primary_edge_input};
            sc_sync_reg <= {sc_sync_reg[0], shared_pad_in};
        end
    end

    function automatic logic edge_ok(input logic prev, input logic now, input logic [3:0] c);
        edge_ok = (c[CTRL_EDGE_RISE] && !prev && now) || (c[CTRL_EDGE_FALL] && prev && !now);
    endfunction : edge_ok

    always_comb begin
        pre_cnt_next = pre_cnt_reg + 8'h01;
        if (!running) pre_cnt_next = 8'h00;
        else if (pre_cnt_reg == ((8'h01 << prescaler_select_reg) - 8'h01)) pre_cnt_next = 8'h00;
        pe_last_next = pe_sync_reg[1];
        pe_fast_edge = edge_ok(pe_last_reg, pe_sync_reg[1], capture_compare_ctrl_reg);
        pf_hist_next = pf_hist_reg;
        sf_hist_next = sf_hist_reg;
        pf_arm_next = pf_arm_reg;
        sf_arm_next = sf_arm_reg;
        pf_capture = 1'b0;
        sf_capture = 1'b0;
        // capture path samples at the prescaled rate so short glitches vanish
        if (pre_tick) begin
            pf_hist_next = {pf_hist_reg[0], pe_sync_reg[1]};
            sf_hist_next = {sf_hist_reg[0], sc_level};
            if (edge_ok(pf_hist_reg[0], pe_sync_reg[1], capture_compare_ctrl_reg))
                pf_arm_next = 1'b1;
            else if (pf_arm_reg && (pe_sync_reg[1] == pf_hist_reg[0])) begin
                pf_arm_next = 1'b0;
                pf_capture = 1'b1;
            end else pf_arm_next = 1'b0;
            if (edge_ok(sf_hist_reg[0], sc_level, capture_compare_ctrl_reg))
                sf_arm_next = 1'b1;
            else if (sf_arm_reg && (sc_level == sf_hist_reg[0])) begin
                sf_arm_next = 1'b0;
                sf_capture = 1'b1;
            end else sf_arm_next = 1'b0;
        end
        // both-edge selection on the capture path takes no capture
        if (capture_compare_ctrl_reg[CTRL_EDGE_RISE] && capture_compare_ctrl_reg[CTRL_EDGE_FALL]) begin
            pf_capture = 1'b0;
            sf_capture = 1'b0;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        capture_compare_ctrl_next = capture_compare_ctrl_reg;
        prescaler_select_next = prescaler_select_reg;
        period_compare_next = period_compare_reg;
        duty_compare_next = duty_compare_reg;
        up_counter16_next = up_counter16_reg;
        cap_a_next = cap_a_reg;
        cap_b_next = cap_b_reg;
        ev_edges_next = ev_edges_reg;
        out_next = out_reg;
        oneshot_run_next = oneshot_run_reg;
        ovf_next = ovf_reg;
        cnt_step = 1'b0;
        if (running) begin
            if (fn == TEC_FN_EVENT) begin
                // first two edges only arm the counter
                if (pe_fast_edge) begin
                    if (ev_edges_reg < 2'(EVENT_START_EDGES)) ev_edges_next = ev_edges_reg + 2'h1;
                    else cnt_step = 1'b1;
                end
            end else cnt_step = pre_tick;
        end
        if (cnt_step) begin
            up_counter16_next = up_counter16_reg + 16'h0001;
            if (up_counter16_reg == 16'hffff) ovf_next = 1'b1;
            if (((op == TEC_OP_CLEAR_MATCH) || (fn == TEC_FN_PPG)) && match_period)
                up_counter16_next = 16'h0000;
            unique case (fn)
                TEC_FN_SQUARE: if (match_period) out_next = !out_reg;
                TEC_FN_PPG: begin
                    if (match_duty) out_next = 1'b0;
                    if (match_period) out_next = 1'b1;
                end
                TEC_FN_ONESHOT: if (oneshot_run_reg) begin
                    if (match_duty) out_next = 1'b1;
                    if (match_period) begin
                        out_next = 1'b0;
                        oneshot_run_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // the pin edge stays live in one-shot, so it restarts the pulse too
        if (running && (fn == TEC_FN_ONESHOT) && (oneshot_trigger_bit || pe_fast_edge)) begin
            up_counter16_next = 16'h0000;
            oneshot_run_next = 1'b1;
        end else if (running && (op == TEC_OP_CLEAR_EDGE) && pe_fast_edge && fn != TEC_FN_EVENT)
            up_counter16_next = 16'h0000;
        if (running && (fn == TEC_FN_PULSE_WIDTH)) begin
            // one full wrap is the longest width; a capture into cap_a_reg clears ovf, so only a wrap in its own cycle stays flagged
            if (pf_capture) begin
                cap_a_next = up_counter16_reg;
                // a wrap in the same cycle wins over the clear
                ovf_next = cnt_step && (up_counter16_reg == 16'hffff);
            end
            if (sf_capture) cap_b_next = up_counter16_reg;
        end
        if (!running) begin
            up_counter16_next = 16'h0000;
            ev_edges_next = 2'h0;
            oneshot_run_next = 1'b0;
            out_next = capture_compare_ctrl_reg[CTRL_OUT_INIT];
        end
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_MODE: mode_next = reg_wdata[4:0];
                ADDR_CTRL: capture_compare_ctrl_next = reg_wdata[3:0];
                ADDR_PRESCALE: prescaler_select_next = reg_wdata[2:0];
                ADDR_PERIOD: period_compare_next = reg_wdata;
                ADDR_DUTY: duty_compare_next = reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_MODE: rdata_next = {11'h000, mode_reg};
                ADDR_CTRL: rdata_next = {12'h000, capture_compare_ctrl_reg};
                ADDR_PRESCALE: rdata_next = {13'h0000, prescaler_select_reg};
                ADDR_PERIOD: rdata_next = period_compare_reg;
                ADDR_DUTY: rdata_next = duty_compare_reg;
                ADDR_COUNT: rdata_next = up_counter16_reg;
                ADDR_CAP_A: rdata_next = cap_a_reg;
                ADDR_CAP_B: rdata_next = cap_b_reg;
                ADDR_STATUS: rdata_next = {13'h0000, ovf_reg, oneshot_run_reg, out_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            up_counter16_reg <= 16'h0000;
            period_compare_reg <= RESET_PERIOD;
            duty_compare_reg <= RESET_DUTY;
            cap_a_reg <= 16'h0000;
            cap_b_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            mode_reg <= 5'h00;
            capture_compare_ctrl_reg <= RESET_CTRL;
            prescaler_select_reg <= RESET_PRESCALE;
            pre_cnt_reg <= 8'h00;
            pe_last_reg <= 1'b0;
            pf_hist_reg <= 2'h0;
            sf_hist_reg <= 2'h0;
            pf_arm_reg <= 1'b0;
            sf_arm_reg <= 1'b0;
            ev_edges_reg <= 2'h0;
            out_reg <= 1'b0;
            oneshot_run_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            up_counter16_reg <= up_counter16_next;
            period_compare_reg <= period_compare_next;
            duty_compare_reg <= duty_compare_next;
            cap_a_reg <= cap_a_next;
            cap_b_reg <= cap_b_next;
            rdata_reg <= rdata_next;
            mode_reg <= mode_next;
            capture_compare_ctrl_reg <= capture_compare_ctrl_next;
            prescaler_select_reg <= prescaler_select_next;
            pre_cnt_reg <= pre_cnt_next;
            pe_last_reg <= pe_last_next;
            pf_hist_reg <= pf_hist_next;
            sf_hist_reg <= sf_hist_next;
            pf_arm_reg <= pf_arm_next;
            sf_arm_reg <= sf_arm_next;
            ev_edges_reg <= ev_edges_next;
            out_reg <= out_next;
            oneshot_run_reg <= oneshot_run_next;
            ovf_reg <= ovf_next;
        end
    end
endmodule : tec_timer

// file: tec_timer_monitor.sv
`timescale 1ns/1ns
module tec_timer_monitor
    import tec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic primary_edge_input,
    input wire logic shared_pad_in,
    input wire logic shared_pad_out,
    input wire logic shared_pad_oe
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic ppg_reg, arm_reg, ok_reg;
    logic [15:0] per_reg, duty_reg, run_reg;
    // the first ppg pulse after a start is ragged, so judging starts one pulse later
    always_ff @(posedge clk_sys) begin
        run_reg <= $rose(shared_pad_out) ? 16'h0001 : run_reg + 16'h0001;
        if ($rose(shared_pad_out)) begin
            arm_reg <= ppg_reg;
            ok_reg <= arm_reg;
        end
        if (reg_wr) begin
            arm_reg <= 1'b0;
            ok_reg <= 1'b0;
        end
        if (reg_wr && reg_addr == ADDR_MODE) ppg_reg <= reg_wdata[4:2] == TEC_FN_PPG;
        if (reg_wr && reg_addr == ADDR_PERIOD) per_reg <= reg_wdata;
        if (reg_wr && reg_addr == ADDR_DUTY) duty_reg <= reg_wdata;
        if (rst) begin
            ppg_reg <= 1'b0;
            arm_reg <= 1'b0;
            ok_reg <= 1'b0;
        end
    end
    chk_pad_exclusive: assert property (!shared_pad_oe |-> !shared_pad_out)
        else $error("pad output driven while pad is an input");
    chk_pad_select: assert property (reg_wr && reg_addr == ADDR_CTRL |=>
        shared_pad_oe == !$past(reg_wdata[CTRL_PAD_IS_CAPTURE])) else $error("pad direction wrong");
    chk_oe_steady: assert property (
        !(reg_wr && reg_addr == ADDR_CTRL) |=> $stable(shared_pad_oe)) else $error("pad flipped");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_TRIG |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_status_out: assert property (reg_rd && reg_addr == ADDR_STATUS && shared_pad_oe |=>
        reg_rdata[0] == $past(shared_pad_out)) else $error("status output bit wrong");
    chk_ppg_period: assert property (ok_reg && $rose(shared_pad_out) |->
        run_reg == per_reg + 16'h0001) else $error("ppg period wrong");
    chk_ppg_width: assert property (ok_reg && $fell(shared_pad_out) |->
        run_reg == duty_reg + 16'h0001) else $error("ppg active width wrong");
    cover property (ok_reg && $rose(shared_pad_out));
    cover property (!shared_pad_oe ##1 shared_pad_oe);
    cover property (reg_rd && reg_addr == ADDR_COUNT ##1 reg_rdata != 16'h0000);
endmodule : tec_timer_monitor

bind tec_timer tec_timer_monitor u_mon (.*);

// file: tec_pins_model.sv
`timescale 1ns/1ns
module tec_pins_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic to_pad,
    input wire logic [7:0] width,
    output logic primary_edge_input,
    output logic pad_drive,
    output logic busy
);
    // one clean pulse per request on either input, then as long low before the next
    initial begin
        primary_edge_input = 1'b0;
        pad_drive = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go) begin
                busy <= 1'b1;
                pad_drive <= to_pad;
                primary_edge_input <= !to_pad;
                repeat (width) @(posedge clk_sys);
                primary_edge_input <= 1'b0;
                pad_drive <= 1'b0;
                repeat (width) @(posedge clk_sys);
                busy <= 1'b0;
            end
        end
    end
endmodule : tec_pins_model

// file: tec_timer_tb.sv
`timescale 1ns/1ns
module tec_timer_tb
    import tec_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, to_pad = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, per, duty;
    logic [7:0] width = 8'h04;
    logic pin, pad_drive, pad_out, pad_oe, busy;
    int err_count = 0, total_checks = 0, n, hi;
    logic [3:0] ra [7] = '{ADDR_MODE, ADDR_CTRL, ADDR_PRESCALE, ADDR_PERIOD, ADDR_DUTY,
        ADDR_COUNT, 4'hf};
    logic [15:0] rx [7] = '{16'h0000, {12'h000, RESET_CTRL}, 16'h0000, RESET_PERIOD, RESET_DUTY,
        16'h0000,
        16'h0000};
    always #50 clk_sys = ~clk_sys;
    tec_timer u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_edge_input(pin),
        .shared_pad_in(pad_oe ? pad_out : pad_drive), .shared_pad_out(pad_out),
        .shared_pad_oe(pad_oe));
    tec_pins_model u_pins (.clk_sys(clk_sys), .go(go), .to_pad(to_pad), .width(width),
        .primary_edge_input(pin), .pad_drive(pad_drive), .busy(busy));
    function automatic logic [15:0] exp_events(input int e);
        return (e > EVENT_START_EDGES) ? 16'(e - EVENT_START_EDGES) : 16'h0000;
    endfunction : exp_events
    // square output toggles once per counter cycle of (period + 1) prescaled ticks
    function automatic logic [15:0] exp_half(input logic [15:0] p, input logic [2:0] s);
        return (p + 16'h0001) << s;
    endfunction : exp_half
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rv = reg_rdata;
    endtask : rd
    // every wait is bounded; a stuck pin or output ends the run as a failure
    task automatic wait_out(input logic lvl, input logic use_busy, output int cyc);
        for (cyc = 0; (use_busy ? busy !== 1'b0 : pad_out !== lvl) && cyc < 3000; cyc++)
            @(posedge clk_sys) #1;
        if (cyc >= 3000) begin
            err_count++;
            final_report();
        end
    endtask : wait_out
    task automatic pulse(input logic p, input logic [7:0] w);
        @(posedge clk_sys);
        go <= 1'b1;
        to_pad <= p;
        width <= w;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys) #1;
        wait_out(1'b0, 1'b1, n);
        repeat (4) @(posedge clk_sys);
    endtask : pulse
    initial begin
        n = $urandom(32'heff53084);
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            check(rv, rx[i]);
        end
        wr(ADDR_CTRL, 16'h0003);
        @(negedge clk_sys);
        check({14'h0000, pad_oe, pad_out}, 16'h0000);
        wr(ADDR_MODE, 16'h0005);
        hi = 3 + $urandom_range(4);
        for (int i = 1; i <= hi; i++) begin
            pulse(1'b0, 8'(2 + $urandom_range(5)));
            rd(ADDR_COUNT);
            check(rv, exp_events(i));
        end
        wr(ADDR_MODE, 16'h0009);
        rd(ADDR_CAP_A);
        per = rv;
        pulse(1'b0, 8'h01);
        rd(ADDR_CAP_A);
        check(rv, per);
        pulse(1'b0, 8'h06);
        rd(ADDR_CAP_A);
        check({15'h0000, rv != per}, 16'h0001);
        rd(ADDR_STATUS);
        check(rv, 16'h0000);
        rd(ADDR_CAP_B);
        per = rv;
        pulse(1'b1, 8'h06);
        rd(ADDR_CAP_B);
        check({15'h0000, rv != per}, 16'h0001);
        wr(ADDR_MODE, 16'h0000);
        wr(ADDR_CTRL, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            per = (i == 0) ? 16'h0002 : 16'(3 + $urandom_range(40));
            duty = (i == 0) ? 16'h0001 : 16'(1 + $urandom_range(per - 2));
            wr(ADDR_PERIOD, per);
            wr(ADDR_DUTY, duty);
            wr(ADDR_MODE, 16'h0011);
            wait_out(1'b1, 1'b0, n);
            wait_out(1'b0, 1'b0, n);
            wait_out(1'b1, 1'b0, n);
            wait_out(1'b0, 1'b0, hi);
            wait_out(1'b1, 1'b0, n);
            check(16'(hi), duty + 16'h0001);
            check(16'(hi + n), per + 16'h0001);
            rd(ADDR_STATUS);
            check(rv, 16'h0001);
            wr(ADDR_MODE, 16'h0000);
        end
        wr(ADDR_PRESCALE, 16'h0001);
        wr(ADDR_PERIOD, 16'h0005);
        wr(ADDR_MODE, 16'h000f);
        wait_out(1'b1, 1'b0, n);
        wait_out(1'b0, 1'b0, hi);
        check(16'(hi), exp_half(16'h0005, 3'h1));
        wr(ADDR_MODE, 16'h0000);
        wr(ADDR_PERIOD, 16'h0020);
        wr(ADDR_DUTY, 16'h0008);
        wr(ADDR_MODE, 16'h0016);
        wr(ADDR_TRIG, 16'h0001);
        wait_out(1'b1, 1'b0, n);
        wait_out(1'b0, 1'b0, n);
        pulse(1'b0, 8'h04);
        wait_out(1'b1, 1'b0, n);
        check({15'h0000, n < 40}, 16'h0001);
        final_report();
    end
endmodule : tec_timer_tb
